// ===== design/spms_defines.svh
// spms_defines.svh: access selects, register bit positions, reset values and counts
// assumes: included by the package and by the port module, nothing else
`ifndef SPMS_DEFINES_SVH
`define SPMS_DEFINES_SVH

// ----------------------------------------
// sizes
// ----------------------------------------
`define SPMS_BYTE_W 8
`define SPMS_HALF_W 8

// ----------------------------------------
// access selects
// ----------------------------------------
`define SPMS_SEL_CR 2'h0
`define SPMS_SEL_CSR 2'h1
`define SPMS_SEL_DR 2'h2

// ----------------------------------------
// control register bits
// ----------------------------------------
`define SPMS_CR_IE 7
`define SPMS_CR_PE 6
`define SPMS_CR_R2 5
`define SPMS_CR_MS 4
`define SPMS_CR_POL 3
`define SPMS_CR_PHA 2
`define SPMS_CR_R1 1
`define SPMS_CR_R0 0
`define SPMS_CR_RST 8'h00

// ----------------------------------------
// control/status register bits
// ----------------------------------------
`define SPMS_CSR_TC 7
`define SPMS_CSR_WC 6
`define SPMS_CSR_OV 5
`define SPMS_CSR_MF 4
`define SPMS_CSR_SM 1
`define SPMS_CSR_SL 0
`define SPMS_CSR_RST 8'h00

// ----------------------------------------
// half periods of the master clock, in core cycles
// ----------------------------------------
`define SPMS_HALF_4 8'h02
`define SPMS_HALF_8 8'h04
`define SPMS_HALF_16 8'h08
`define SPMS_HALF_32 8'h10
`define SPMS_HALF_64 8'h20
`define SPMS_HALF_128 8'h40
`define SPMS_HALF_ONE 8'h01

`endif

// ===== design/spms_pkg.sv
// spms_pkg.sv: types shared by the serial port and its bench
// assumes: spms_defines.svh on the include path
`include "spms_defines.svh"

package spms_pkg;

  // ----------------------------------------
  // cpu access strobe with its data
  // ----------------------------------------
  typedef struct packed {
    logic en;
    logic wr;
    logic [1:0] sel;
    logic [`SPMS_BYTE_W-1:0] wdata;
  } spms_acc_t;

  // ----------------------------------------
  // pin drive: level and output enable per pin
  // ----------------------------------------
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spms_pins_t;

  typedef enum logic {
    SPMS_IDLE,
    SPMS_RUN
  } spms_state_t;

endpackage

// ===== design/spms_port.sv
// spms_port.sv: byte-wide synchronous serial port, master or slave
// assumes: cpu strobes on core_clk; slave shifting runs on the incoming serial clock
`timescale 1ns/1ps
`include "spms_defines.svh"

module spms_port
  import spms_pkg::*;
#(
  parameter int DATA_W = `SPMS_BYTE_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire spms_acc_t acc,
  output spms_acc_t acc_echo_unused,
  output logic [DATA_W-1:0] rd_data,
  output logic irq,
  input wire logic sck_link,
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  input wire logic ss_n_i,
  output spms_pins_t pins
);

  localparam int CW = $clog2(DATA_W);
  localparam int EW = CW + 1;
  localparam int NS = 4;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (DATA_W != `SPMS_BYTE_W) begin : g_chk
    $error("spms_port serves only byte-wide data");
  end

  // ----------------------------------------
  // rate decode
  // ----------------------------------------
  function automatic logic [`SPMS_HALF_W-1:0] half_of(input logic [2:0] code);
    case (code)
      3'h4: half_of = `SPMS_HALF_4;
      3'h0: half_of = `SPMS_HALF_8;
      3'h1: half_of = `SPMS_HALF_16;
      3'h6: half_of = `SPMS_HALF_32;
      3'h2: half_of = `SPMS_HALF_64;
      default: half_of = `SPMS_HALF_128;
    endcase
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [DATA_W-1:0] cr;
  logic software_select_management_bit, software_select_level_bit;
  logic tc, wc, ov, mf;
  logic tc_arm, wc_arm, mf_arm;
  logic [DATA_W-1:0] tx_hold, rx_buf;
  spms_state_t st;
  logic [`SPMS_HALF_W-1:0] half_cnt;
  logic [EW-1:0] edge_cnt;
  logic sck_ph;
  logic [DATA_W-1:0] sh, rx_m;
  logic slv_busy;
  logic [NS-1:0] s1, s2;
  logic dn_prev, st_prev;
  logic [1:0] cap_d, done_d;

  // link domain
  logic [DATA_W-1:0] rx_sh, rx_word;
  logic [CW-1:0] cnt, out_idx;
  logic done_tgl, start_tgl;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic pe = cr[`SPMS_CR_PE];
  wire logic ms = cr[`SPMS_CR_MS];
  wire logic pol = cr[`SPMS_CR_POL];
  wire logic pha = cr[`SPMS_CR_PHA];
  wire logic ie = cr[`SPMS_CR_IE];
  wire logic [2:0] rate = {cr[`SPMS_CR_R2], cr[`SPMS_CR_R1], cr[`SPMS_CR_R0]};
  wire logic rd = acc.en & ~acc.wr;
  wire logic wr = acc.en & acc.wr;
  wire logic cr_wr = wr & (acc.sel == `SPMS_SEL_CR);
  wire logic csr_rd = rd & (acc.sel == `SPMS_SEL_CSR);
  wire logic csr_acc = acc.en & (acc.sel == `SPMS_SEL_CSR);
  wire logic dr_rd = rd & (acc.sel == `SPMS_SEL_DR);
  wire logic dr_wr = wr & (acc.sel == `SPMS_SEL_DR);
  wire logic dr_acc = dr_rd | dr_wr;

  // ----------------------------------------
  // pin synchronisers: ss_n, miso, done and start toggles
  // ----------------------------------------
  wire logic [NS-1:0] s_in = {ss_n_i, miso_i, done_tgl, start_tgl};

  for (genvar i = 0; i < NS; i++) begin : g_sync
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        s1[i] <= 1'b0;
        s2[i] <= 1'b0;
      end else begin
        s1[i] <= s_in[i];
        s2[i] <= s1[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dn_prev <= 1'b0;
      st_prev <= 1'b0;
    end else begin
      dn_prev <= s2[1];
      st_prev <= s2[0];
    end
  end

  wire logic ss_pin_hi = s2[3];
  wire logic miso_s = s2[2];
  wire logic slv_done = s2[1] ^ dn_prev;
  wire logic slv_start = s2[0] ^ st_prev;
  wire logic ss_hi = software_select_management_bit ? software_select_level_bit : ss_pin_hi;
  wire logic slave_on = pe & ~ms;

  // ----------------------------------------
  // master engine
  // ----------------------------------------
  wire logic m_run = (st == SPMS_RUN);
  wire logic busy = m_run | (|done_d) | slv_busy;
  wire logic wr_blocked = tc & ~tc_arm;
  wire logic slv_sel_col = slave_on & ~pha & ~ss_hi;
  wire logic wr_col = dr_wr & ~wr_blocked & (busy | slv_sel_col);
  wire logic wr_ok = dr_wr & ~wr_blocked & ~busy & ~slv_sel_col;
  wire logic m_start = wr_ok & pe & ms;
  wire logic half_hit = (half_cnt == half_of(rate) - `SPMS_HALF_ONE);
  wire logic last_edge = (edge_cnt == EW'(2 * DATA_W - 1));
  wire logic cap_now = (edge_cnt[0] == pha);
  wire logic fault = ms & ~ss_hi;
  wire logic m_tick = m_run & ms & ~fault & half_hit;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= SPMS_IDLE;
      half_cnt <= '0;
      edge_cnt <= '0;
      sck_ph <= 1'b0;
      sh <= '0;
      rx_m <= '0;
      cap_d <= '0;
      done_d <= '0;
    end else begin
      cap_d <= {cap_d[0], m_tick & cap_now};
      done_d <= {done_d[0], m_tick & last_edge};
      rx_m <= cap_d[1] ? {rx_m[DATA_W-2:0], miso_s} : rx_m;
      case (st)
        SPMS_IDLE: begin
          sck_ph <= 1'b0;
          half_cnt <= '0;
          edge_cnt <= '0;
          if (m_start) begin
            sh <= acc.wdata;
            st <= SPMS_RUN;
          end
        end
        SPMS_RUN: begin
          if (fault | ~ms) begin
            st <= SPMS_IDLE;
          end else if (half_hit) begin
            half_cnt <= '0;
            sck_ph <= ~sck_ph;
            edge_cnt <= edge_cnt + EW'(1);
            if (!cap_now && edge_cnt != '0) begin
              sh <= {sh[DATA_W-2:0], 1'b0};
            end
            if (last_edge) begin
              st <= SPMS_IDLE;
            end
          end else begin
            half_cnt <= half_cnt + `SPMS_HALF_ONE;
          end
        end
        default: st <= SPMS_IDLE;
      endcase
    end
  end

  wire logic [DATA_W-1:0] m_byte = cap_d[1] ? {rx_m[DATA_W-2:0], miso_s} : rx_m;

  // ----------------------------------------
  // slave busy tracking
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      slv_busy <= 1'b0;
    end else if (slv_start) begin
      slv_busy <= 1'b1;
    end else if (slv_done | ss_hi | ~slave_on) begin
      slv_busy <= 1'b0;
    end
  end

  // ----------------------------------------
  // flags and control
  // ----------------------------------------
  wire logic any_done = done_d[1] | (slv_done & slave_on);
  wire logic tc_clr = tc_arm & (dr_rd | (dr_wr & ~ms));
  wire logic wc_clr = wc_arm & dr_acc;
  wire logic mf_clr = mf_arm & cr_wr;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tc <= 1'b0;
      tc_arm <= 1'b0;
      ov <= 1'b0;
      wc <= 1'b0;
      wc_arm <= 1'b0;
      mf <= 1'b0;
      mf_arm <= 1'b0;
    end else begin
      tc <= any_done | (tc & ~tc_clr);
      tc_arm <= ~any_done & ~tc_clr & (tc_arm | (csr_acc & tc));
      ov <= (any_done & tc & ~tc_clr) | (ov & ~csr_rd);
      wc <= wr_col | (wc & ~wc_clr);
      wc_arm <= ~wr_col & ~wc_clr & (wc_arm | (csr_rd & wc));
      mf <= fault | (mf & ~mf_clr);
      mf_arm <= ~fault & ~mf_clr & (mf_arm | (csr_rd & mf));
    end
  end

  wire logic [DATA_W-1:0] cr_gate = {1'b1, ~(mf & ~mf_arm), 1'b1,
    ~(mf & ~mf_arm), {(DATA_W - 4){1'b1}}};

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cr <= `SPMS_CR_RST;
    end else if (fault) begin
      cr[`SPMS_CR_PE] <= 1'b0;
      cr[`SPMS_CR_MS] <= 1'b0;
    end else if (cr_wr) begin
      cr <= acc.wdata & cr_gate;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      software_select_management_bit <= 1'(`SPMS_CSR_RST >> `SPMS_CSR_SM);
      software_select_level_bit <= 1'(`SPMS_CSR_RST >> `SPMS_CSR_SL);
    end else if (wr & (acc.sel == `SPMS_SEL_CSR)) begin
      software_select_management_bit <= acc.wdata[`SPMS_CSR_SM];
      software_select_level_bit <= acc.wdata[`SPMS_CSR_SL];
    end
  end

  // ----------------------------------------
  // data buffers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_hold <= '0;
      rx_buf <= '0;
    end else begin
      if (wr_ok) begin
        tx_hold <= acc.wdata;
      end
      if (any_done & (~tc | tc_clr)) begin
        rx_buf <= slave_on ? rx_word : m_byte;
      end
    end
  end

  // ----------------------------------------
  // read data and interrupt
  // ----------------------------------------
  wire logic [DATA_W-1:0] csr_val = {tc, wc, ov, mf, 2'b00, software_select_management_bit, software_select_level_bit};
  wire logic [DATA_W-1:0] rd_mux = (acc.sel == `SPMS_SEL_CR) ? cr :
    (acc.sel == `SPMS_SEL_CSR) ? csr_val :
    (acc.sel == `SPMS_SEL_DR) ? rx_buf : '0;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= '0;
    end else if (rd) begin
      rd_data <= rd_mux;
    end
  end

  assign irq = ie & (tc | mf | ov);
  assign acc_echo_unused = '0;

  // ----------------------------------------
  // slave shifter on the link clock
  // ----------------------------------------
  wire logic ss_raw_hi = software_select_management_bit ? software_select_level_bit : ss_n_i;
  wire logic link_on = slave_on & ~ss_raw_hi;
  wire logic link_rst_n = nrst & link_on;
  wire logic sck_cap = sck_link ^ (pol ^ pha);

  always_ff @(posedge sck_cap or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rx_sh <= '0;
      rx_word <= '0;
      cnt <= '0;
    end else begin
      rx_sh <= {rx_sh[DATA_W-2:0], mosi_i};
      cnt <= cnt + CW'(1);
      if (cnt == CW'(DATA_W - 1)) begin
        rx_word <= {rx_sh[DATA_W-2:0], mosi_i};
      end
    end
  end

  always_ff @(posedge sck_cap or negedge nrst) begin
    if (!nrst) begin
      done_tgl <= 1'b0;
      start_tgl <= 1'b0;
    end else if (link_on) begin
      start_tgl <= start_tgl ^ (cnt == '0);
      done_tgl <= done_tgl ^ (cnt == CW'(DATA_W - 1));
    end
  end

  always_ff @(negedge sck_cap or negedge link_rst_n) begin
    if (!link_rst_n) begin
      out_idx <= '0;
    end else begin
      out_idx <= cnt;
    end
  end

  wire logic [DATA_W-1:0] tx_shift = tx_hold << out_idx;

  // ----------------------------------------
  // pins
  // ----------------------------------------
  assign pins.sck_o = pol ^ sck_ph;
  assign pins.sck_oe = pe & ms;
  assign pins.mosi_o = sh[DATA_W-1];
  assign pins.mosi_oe = pe & ms;
  assign pins.miso_o = tx_shift[DATA_W-1];
  assign pins.miso_oe = slave_on & ~ss_hi;

endmodule

// ===== sim/spms_port_assertions.sv
// spms_port_assertions.sv: port-level checks for the serial port
// assumes: bound to spms_port from the bench top; core_clk domain only
`timescale 1ns/1ps
module spms_port_assertions
  import spms_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire spms_acc_t acc,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic irq,
  input wire logic ss_n_i,
  input wire spms_pins_t pins
);
  // ----------------------------------------
  // shadow of written control and select mode
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] cr;
  logic software_select_management_bit;
  wire cr_wr = acc.en && acc.wr && acc.sel == 2'h0;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cr <= 8'h00;
      software_select_management_bit <= 1'b0;
    end else begin
      if (cr_wr) cr <= acc.wdata;
      if (acc.en && acc.wr && acc.sel == 2'h1) software_select_management_bit <= acc.wdata[1];
    end
  end
  sequence s_sel_drop;
    $fell(ss_n_i) && !software_select_management_bit && pins.sck_oe;
  endsequence
  sequence s_master_on;
    cr_wr && acc.wdata[4] && acc.wdata[6] ##2 pins.sck_oe;
  endsequence
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_rd_hold: assert property (!(acc.en && !acc.wr) |=> $stable(rd_data))
    else $error("read data moved without a read");
  a_sck_idle: assert property (s_master_on |-> pins.sck_o == $past(acc.wdata[3], 2))
    else $error("serial clock idle level differs from polarity");
  a_fault_off: assert property (s_sel_drop |-> ##[1:4] !pins.sck_oe && !pins.mosi_oe)
    else $error("master fault did not release the pins");
  a_fault_irq: assert property (s_sel_drop and cr[7] |-> ##[1:5] irq)
    else $error("master fault raised no interrupt");
  a_irq_gate: assert property (!cr[7] |-> !irq)
    else $error("interrupt while disabled");
  a_slave_sck: assert property (cr_wr && !acc.wdata[4] |=> !pins.sck_oe)
    else $error("slave drives the serial clock");
  a_slave_miso: assert property (cr[6] && !cr[4] && !software_select_management_bit && $fell(ss_n_i)
    |-> ##[1:5] pins.miso_oe)
    else $error("selected slave does not drive miso");
  a_off_quiet: assert property (!cr[6] [*3] |-> !pins.miso_oe && !pins.sck_oe
    && !pins.mosi_oe)
    else $error("disabled port drives a pin");
endmodule

// ===== sim/spms_port_tb_top.sv
// spms_port_tb_top.sv: self-checking bench for the serial port
// assumes: spms_slave_model and spms_port_assertions compiled before it
`timescale 1ns/1ps
module spms_port_tb_top
  import spms_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  spms_acc_t acc = '0;
  logic [7:0] rd_data, m_rx, v, a, b, g, s_tx;
  logic irq, m_miso;
  logic ss_n = 1'b1, b_sck = 1'b0, b_mosi = 1'b0, m_sel_n = 1'b1, m_pol = 1'b0, m_pha = 1'b0;
  logic [7:0] m_tx = 8'h00;
  spms_pins_t pins;
  int error_cnt = 0;
  int tests_run = 0;
  wire sck_w = pins.sck_oe ? pins.sck_o : b_sck;
  wire mosi_w = pins.mosi_oe ? pins.mosi_o : b_mosi;
  wire miso_w = pins.miso_oe ? pins.miso_o : m_miso;
  always #4 core_clk = ~core_clk;
  spms_port spms_port_i (.core_clk(core_clk), .nrst(nrst), .acc(acc), .acc_echo_unused(),
    .rd_data(rd_data), .irq(irq), .sck_link(sck_w), .sck_i(sck_w), .mosi_i(mosi_w),
    .miso_i(miso_w), .ss_n_i(ss_n), .pins(pins));
  spms_slave_model spms_slave_model_i (.sck(sck_w), .sel_n(m_sel_n), .mosi(mosi_w),
    .pol(m_pol), .pha(m_pha), .tx(m_tx), .miso(m_miso), .rx(m_rx));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acs(input logic wr, input logic [1:0] s, input logic [7:0] d);
    @(posedge core_clk);
    acc <= '{1'b1, wr, s, d};
    @(posedge core_clk);
    acc <= '0;
    #1 v = rd_data;
  endtask
  function automatic int half(input logic [2:0] r);
    case (r)
      3'h4: return 2;
      3'h0: return 4;
      3'h1: return 8;
      3'h6: return 16;
      3'h2: return 32;
      default: return 64;
    endcase
  endfunction
  task automatic mxfer(input logic [2:0] r, input logic pol, input logic pha,
    input logic [7:0] d);
    int tg, t0, t1, n;
    logic last, hit;
    m_pol = pol;
    m_pha = pha;
    m_tx = 8'($urandom);
    b_sck = pol;
    hit = 1'b0;
    acs(1'b1, 2'h0, {1'b1, 1'b0, r[2], 1'b0, pol, pha, r[1:0]});
    acs(1'b1, 2'h1, 8'h03);
    acs(1'b1, 2'h0, {1'b1, 1'b1, r[2], 1'b1, pol, pha, r[1:0]});
    chk("sck idle", {7'h00, pins.sck_o}, {7'h00, pol});
    m_sel_n = 1'b0;
    acs(1'b1, 2'h2, d);
    tg = 0;
    t0 = 0;
    t1 = 0;
    last = pins.sck_o;
    for (n = 0; n < 3000 && !irq; n++) begin
      @(posedge core_clk);
      acc <= (tg == 4 && !hit) ? {1'b1, 1'b1, 2'h2, ~d} : '0;
      hit = hit | (tg == 4);
      #1;
      if (pins.sck_o !== last) begin
        tg++;
        last = pins.sck_o;
        if (tg == 1) t0 = n;
        t1 = n;
      end
    end
    chk("edges", 8'(tg), 8'h10);
    chk("span", 8'((t1 - t0) / 15), 8'(half(r)));
    acs(1'b1, 2'h2, 8'h5A);
    repeat (20 * half(r)) @(posedge core_clk);
    chk("far rx", m_rx, d);
    m_sel_n = 1'b1;
    acs(1'b0, 2'h1, 8'h00);
    chk("status", v, 8'hC3);
    acs(1'b0, 2'h2, 8'h00);
    chk("rx byte", v, m_tx);
    chk("irq off", {7'h00, irq}, 8'h00);
    acs(1'b0, 2'h1, 8'h00);
    chk("status clr", v, 8'h03);
  endtask
  task automatic frame(input logic [7:0] d, output logic [7:0] got);
    @(posedge core_clk) ss_n <= 1'b0;
    #29;
    for (int i = 7; i >= 0; i--) begin
      b_sck = 1'b1;
      b_mosi = d[i];
      #32;
      b_sck = 1'b0;
      got = {got[6:0], miso_w};
      #32;
    end
    b_mosi = ~b_mosi;
    repeat (8) @(posedge core_clk);
    ss_n <= 1'b1;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    #400000;
    error_cnt++;
    complete_run;
  end
  initial begin
    void'($urandom(25638));
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk) ss_n <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      mxfer(3'(i), i[0], i[1], i == 0 ? 8'h80 : i == 1 ? 8'h01 : 8'($urandom));
    end
    @(posedge core_clk) ss_n <= 1'b1;
    b_sck = 1'b0;
    acs(1'b1, 2'h0, 8'h00);
    acs(1'b1, 2'h1, 8'h00);
    acs(1'b1, 2'h0, 8'hD0);
    @(posedge core_clk) ss_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1 chk("fault", {6'h00, pins.sck_oe, irq}, 8'h01);
    acs(1'b1, 2'h0, 8'hD0);
    @(posedge core_clk) ss_n <= 1'b1;
    #1 chk("refused", {7'h00, pins.sck_oe}, 8'h00);
    acs(1'b0, 2'h1, 8'h00);
    chk("fault status", v, 8'h10);
    acs(1'b1, 2'h0, 8'hD0);
    repeat (3) @(posedge core_clk);
    #1 chk("restored", {6'h00, pins.sck_oe, irq}, 8'h02);
    acs(1'b1, 2'h0, 8'h00);
    acs(1'b1, 2'h0, 8'hC4);
    s_tx = 8'($urandom);
    a = 8'($urandom);
    b = 8'($urandom);
    acs(1'b1, 2'h2, s_tx);
    frame(a, g);
    chk("slave out", g, s_tx);
    chk("slave irq", {7'h00, irq}, 8'h01);
    frame(b, g);
    acs(1'b0, 2'h1, 8'h00);
    chk("ovr status", v, 8'hA0);
    acs(1'b0, 2'h2, 8'h00);
    chk("kept byte", v, a);
    acs(1'b0, 2'h1, 8'h00);
    chk("ovr clr", v, 8'h00);
    @(posedge core_clk) ss_n <= 1'b0;
    acs(1'b1, 2'h0, 8'hC0);
    acs(1'b1, 2'h2, 8'h3C);
    acs(1'b0, 2'h1, 8'h00);
    chk("slave write_collision_flag", v, 8'h40);
    complete_run;
  end
endmodule

bind spms_port spms_port_assertions #(.DATA_W(DATA_W)) spms_port_assertions_i (
  .core_clk(core_clk), .nrst(nrst), .acc(acc), .rd_data(rd_data), .irq(irq),
  .ss_n_i(ss_n_i), .pins(pins));

// ===== sim/spms_slave_model.sv
// spms_slave_model.sv: behavioural far-end slave for master transfers
// assumes: sck and mosi come from the port; sel_n, mode and tx from the bench
`timescale 1ns/1ps
module spms_slave_model (
  input wire logic sck,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic pol,
  input wire logic pha,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic [7:0] sh = 8'h00;
  logic first = 1'b0;
  // rising edge of cap is the capture edge
  wire cap = sck ^ pol ^ pha;
  initial miso = 1'b0;
  initial rx = 8'h00;
  always @(negedge sel_n) begin
    sh = tx;
    first = pha;
    miso = tx[7];
  end
  // released line shows the inverse of the last bit
  always @(posedge sel_n) miso = ~miso;
  always @(posedge cap) begin
    if (!sel_n) rx = {rx[6:0], mosi};
  end
  always @(negedge cap) begin
    if (!sel_n && first) first = 1'b0;
    else if (!sel_n) begin
      sh = {sh[6:0], 1'b0};
      miso = sh[7];
    end
  end
endmodule
